// *** bench/cmd_port_props.sv ***
// concurrent checks on the pins and memory side of the serial command port
module cmd_port_props #(
   parameter MEM_SIZE = 8192
) (
   input wire clk,
   input wire resetn,
   input wire scl_in,
   input wire sda_out,
   input wire sda_oe,
   input wire [15:0] read_only_area_setting,
   input wire rf_busy,
   input wire mem_req,
   input wire mem_we,
   input wire [15:0] mem_addr,
   input wire [7:0] control_reg,
   input wire host_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // ==========================================================================
   // bus pin checks and quiet outputs after reset
   chk_open_drain: assert property (sda_oe |-> !sda_out) else $error("data line driven high");
   chk_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved with clock high");
   chk_reset_quiet: assert property ($rose(resetn) |-> !sda_oe && !mem_req && !host_busy && control_reg == 8'h00)
      else $error("outputs active after reset");
   // ==========================================================================
   // memory and control checks
   chk_busy_no_mem: assert property (mem_req |-> !rf_busy) else $error("memory used during rf work");
   chk_addr_in_mem: assert property (mem_req |-> mem_addr < MEM_SIZE) else $error("address beyond memory");
   chk_ro_protect: assert property (mem_req && mem_we |-> (mem_addr[15:8] < read_only_area_setting[15:8] ||
      mem_addr[15:8] > read_only_area_setting[7:0])) else $error("write into protected pages");
   chk_ctrl_reserved: assert property (control_reg[2:0] == 3'h0) else $error("reserved control bits set");
   chk_ctrl_rf_lock: assert property ($changed(control_reg) |-> !rf_busy && !$past(rf_busy))
      else $error("control changed during rf work");
   // main scenarios reached
   cov_mem_write: cover property (mem_req && mem_we);
   cov_mem_read: cover property (mem_req && !mem_we);
   cov_ctrl_write: cover property ($changed(control_reg));
   cov_ack_drive: cover property (sda_oe && scl_in);
endmodule
bind i2c_host_command_port cmd_port_props #(.MEM_SIZE(MEM_SIZE)) u_props (.clk(clk), .resetn(resetn),
   .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .read_only_area_setting(read_only_area_setting),
   .rf_busy(rf_busy), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .control_reg(control_reg),
   .host_busy(host_busy));

// *** bench/i2c_host_model.sv ***
// two-wire bus controller standing in for the host
module i2c_host_model (
   output logic scl,
   output logic sda_low,
   input wire sda
);
   timeunit 1ns;
   timeprecision 1ns;
   // bus idle: both lines released
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // start or repeated start, only the host opens a frame
   task start_cond();
      sda_low = 1'b0;
      #100 scl = 1'b1;
      #100 sda_low = 1'b1;
      #100 scl = 1'b0;
      #100;
   endtask
   // stop: data rises while clock high, clock then rests high
   task stop_cond();
      sda_low = 1'b1;
      #100 scl = 1'b1;
      #100 sda_low = 1'b0;
      #100;
   endtask
   // one bit: 300 ns low, 100 ns high, sampled mid high
   task bit_x(input logic b, output logic r);
      sda_low = !b;
      #150 scl = 1'b1;
      #50 r = sda;
      #50 scl = 1'b0;
      #150;
   endtask
   // byte then acknowledge bit, first byte of a frame is the address
   task xbyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(a, ack);
   endtask
endmodule

// *** bench/test_i2c_host_command_port.sv ***
// self-checking bench for the serial command port
`include "cmd_port_defs.vh"
module test_i2c_host_command_port;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] own_addr = 7'h52;
   logic clk = 1'b0, resetn = 1'b0, rf_busy = 1'b0, tunnel_mode = 1'b0, t_rd = 1'b0, t_wr = 1'b0;
   logic cfg_err = 1'b1, mem_done = 1'b0;
   logic [3:0] ev = 4'h0;
   logic [7:0] wd, r, ctl_exp;
   logic [15:0] wa, a;
   logic [31:0] seed = 32'd67081;
   int fails = 0, n_compared = 0, tn = 0;
   wire sda_out, sda_oe, mem_req, mem_we, host_busy, scl, sda_low;
   wire [15:0] mem_addr;
   wire [7:0] mem_wdata, control_reg;
   wire [7:0] mem_rdata = mem_addr[7:0] ^ 8'h5A;
   wire sda = !(sda_low || sda_oe); // pull-up when nobody drives
   // ==========================================================================
   // clock, memory stand-in and instances
   always #25 clk = ~clk;
   // memory write completes one cycle after the request
   always @(posedge clk) begin
      mem_done <= mem_req && mem_we;
      if (mem_req && mem_we) begin
         wa <= mem_addr;
         wd <= mem_wdata;
      end
   end
   i2c_host_model host (.scl(scl), .sda_low(sda_low), .sda(sda));
   i2c_host_command_port dut (.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .target_address_setting(own_addr), .read_only_area_setting(16'h1010), .rf_busy(rf_busy),
      .tunnel_mode(tunnel_mode), .tunnel_read_req(t_rd), .tunnel_write_req(t_wr), .rf_mem_write_event(ev[3]),
      .rf_mem_read_event(ev[2]), .rf_transmit_done_event(ev[1]), .field_detect_event(ev[0]),
      .mem_rdata(mem_rdata), .mem_done(mem_done), .cfg_check_error(cfg_err), .sum_check_error(1'b0),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .control_reg(control_reg), .host_busy(host_busy));
   // ==========================================================================
   // helpers
   function automatic logic [15:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   function automatic logic [7:0] exp_rd(input logic [15:0] ad);
      return ad[7:0] ^ 8'h5A;
   endfunction
   task check(input string nm, input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task summarize();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // write frame of n bytes, right-aligned in w, first byte highest
   task wframe(input logic [6:0] ad, input logic [39:0] w, input int n, output logic ack);
      logic [7:0] d;
      logic k;
      @(negedge clk);
      #13 host.start_cond();
      host.xbyte({ad, 1'b0}, 1'b1, d, ack);
      for (int i = n - 1; i >= 0; i--) host.xbyte(w[8*i +: 8], 1'b1, d, k);
      host.stop_cond();
   endtask
   // read frame: status byte and optionally one data byte
   task rframe(input int nr, output logic [7:0] s, output logic [7:0] b);
      logic k;
      @(negedge clk);
      #13 host.start_cond();
      host.xbyte({own_addr, 1'b1}, 1'b1, s, k);
      host.xbyte(8'hFF, nr == 0, s, k);
      if (nr > 0) host.xbyte(8'hFF, 1'b1, b, k);
      host.stop_cond();
   endtask
   task cmd(input logic [39:0] w, input int nw, input logic [7:0] es, input int nr, input logic [7:0] ed);
      logic k;
      logic [7:0] s, b;
      if (nw > 0) wframe(own_addr, w, nw, k);
      rframe(nr, s, b);
      check("status", s, es);
      if (nr > 0) check("data", b, ed);
      if (nw > 0) check("ack", {7'h00, k}, 8'h00);
      tn++;
      $display("test %0d done", tn);
   endtask
   // ==========================================================================
   // main sequence
   initial begin
      logic k;
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      cmd(0, 0, 8'h00, 0, 0);
      for (int i = 0; i < 4; i++) begin
         @(negedge clk) ev = 4'h8 >> i;
         @(negedge clk) ev = 4'h0;
         cmd(0, 0, 8'h80 >> i, 0, 0);
      end
      r = 8'(xs());
      ctl_exp = r & `CTRL_RESERVED_MASK;
      cmd({`OP_REG_WRITE, r}, 2, 8'h05, 0, 0);
      check("ctrl", control_reg, ctl_exp);
      cmd(`OP_REG_READ, 1, 8'h05, 1, ctl_exp | 8'h02);
      for (int i = 0; i < 3; i++) begin
         a = xs() & 16'h0FFF;
         r = 8'(xs());
         cmd({`OP_MEM_READ, a, 8'h01}, 4, 8'h05, 1, exp_rd(a));
         cmd({`OP_MEM_WRITE, a, 8'h01, r}, 5, 8'h05, 0, 0);
         check("waddr hi", wa[15:8], a[15:8]);
         check("waddr lo", wa[7:0], a[7:0]);
         check("wdata", wd, r);
      end
      cmd({`OP_MEM_READ, a, `READ_LEN_MAX}, 4, 8'h05, 0, 0);
      cmd({`OP_MEM_READ, a, 8'h00}, 4, 8'h0A, 0, 0);
      cmd({`OP_MEM_READ, a, 8'hFF}, 4, 8'h0A, 0, 0);
      cmd({`OP_MEM_READ, 16'h2000, 8'h01}, 4, 8'h0A, 0, 0);
      cmd({`OP_MEM_WRITE, 16'h1005, 8'h01, r}, 5, 8'h0B, 0, 0);
      cmd(8'h33, 1, 8'h08, 0, 0);
      cmd(`OP_TUNNEL_A, 1, 8'h09, 0, 0);
      wframe(own_addr, {`OP_MEM_READ, a[15:8]}, 2, k);
      cmd({a[7:0], 8'h01}, 2, 8'h05, 1, exp_rd(a));
      wframe(own_addr ^ 7'h01, {`OP_REG_WRITE, 8'hFF}, 2, k);
      check("foreign ack", {7'h00, k}, 8'h01);
      check("ctrl kept", control_reg, ctl_exp);
      @(negedge clk) rf_busy = 1'b1;
      cmd({`OP_MEM_READ, a, 8'h01}, 4, 8'h07, 0, 0);
      cmd({`OP_MEM_WRITE, a, 8'h01, r}, 5, 8'h07, 0, 0);
      cmd(0, 0, 8'h07, 0, 0);
      cmd(`OP_REG_READ, 1, 8'h05, 1, ctl_exp | 8'h02);
      cmd({`OP_REG_WRITE, 8'h00}, 2, 8'h0A, 0, 0);
      cmd(`OP_TUNNEL_B, 1, 8'h09, 0, 0);
      @(negedge clk) rf_busy = 1'b0;
      tunnel_mode = 1'b1;
      @(negedge clk) t_rd = 1'b1;
      @(negedge clk) t_rd = 1'b0;
      cmd(0, 0, 8'h01, 0, 0);
      @(negedge clk) t_wr = 1'b1;
      @(negedge clk) t_wr = 1'b0;
      cmd(0, 0, 8'h03, 0, 0);
      @(negedge clk) tunnel_mode = 1'b0;
      @(negedge clk) resetn = 1'b0;
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      check("ctrl reset", control_reg, 8'h00);
      cmd(0, 0, 8'h00, 0, 0);
      summarize();
   end
   // watchdog against a hung transfer
   initial begin
      #3000000;
      fails++;
      summarize();
   end
endmodule

// *** logic/cmd_port_defs.vh ***
// constants for the serial command port of the tag
`ifndef CMD_PORT_DEFS_VH
`define CMD_PORT_DEFS_VH
`define OP_MEM_READ 8'h08
`define OP_MEM_WRITE 8'h18
`define OP_REG_READ 8'h68
`define OP_REG_WRITE 8'h78
`define OP_TUNNEL_A 8'hA2
`define OP_TUNNEL_B 8'hA4
`define RES_NONE 4'h0
`define RES_TUN_READ 4'h1
`define RES_TUN_WRITE 4'h3
`define RES_BUSY 4'h7
`define RES_NORMAL 4'h5
`define RES_UNIMPL 4'h8
`define RES_TUN_ERR 4'h9
`define RES_PARAM 4'hA
`define RES_RDONLY 4'hB
`define RES_HOST_BUSY 4'hF
`define READ_LEN_MAX 8'hFE
`define WRITE_LEN_MAX 8'hFB
`define HDR_LEN_MEM 8'h04
`define HDR_LEN_REG_WRITE 8'h02
`define BIT_WR_FLAG 7
`define BIT_RD_FLAG 6
`define BIT_TX_FLAG 5
`define BIT_DET_FLAG 4
`define CTRL_RESERVED_MASK 8'hF8
`endif

// *** logic/i2c_host_command_port.v ***
// two-wire target that takes host command frames and returns response frames
// Summary of operation
// (R01) host is the bus controller; the device only answers as a target
// (R02) address match with direction low: following bytes are a command
// (R03) address match with direction high: device drives the response bytes
// (R04) a fully received command is processed; outcome returned on next read
// (R05) a read with no prior command write returns current status
// (R06) frames may split at byte boundaries; data field at most two pieces
// (R07) frame is one address byte then zero to 255 data bytes
// (R08) own target address comes from a configuration field in memory
// (R09) status bits 7..4: memory write, memory read, transmit, field detect
// (R10) status low nibble holds the latest result code
// (R11) code 0x0 nothing to report, 0x5 normal completion
// (R12) code 0x1 tunnel read request, 0x3 tunnel write request
// (R13) code 0x8 for an unimplemented command byte
// (R14) code 0xA for address outside memory or length out of range
// (R15) code 0xB for writes into the read-only region
// (R16) code 0x9 for tunnel commands while idle or during RF work
// (R17) during RF work, read, write and status answer busy 0x7
// (R18) code 0xF while a host command is still in progress
// (R19) during RF work, register read ends 0x5, register write 0xA
// (R20) codes 0x08 mem read, 0x18 mem write, 0x68 reg read, 0x78 reg write
// (R21) status request has no code: a read not preceded by a command
// (R22) mem read has 2-byte address, length 1..254; no data on error or busy
// (R23) host keeps write length within 1..251, data after length
// (R24) foreign addresses are ignored and the data line stays released
module i2c_host_command_port #(
   parameter MEM_ADDR_W = 13,
   parameter MEM_SIZE = 8192
) (
   input wire clk,
   input wire resetn,
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   input wire [6:0] target_address_setting,
   input wire [15:0] read_only_area_setting,
   input wire rf_busy,
   input wire tunnel_mode,
   input wire tunnel_read_req,
   input wire tunnel_write_req,
   input wire rf_mem_write_event,
   input wire rf_mem_read_event,
   input wire rf_transmit_done_event,
   input wire field_detect_event,
   input wire [7:0] mem_rdata,
   input wire mem_done,
   input wire cfg_check_error,
   input wire sum_check_error,
   output reg mem_req,
   output reg mem_we,
   output reg [15:0] mem_addr,
   output reg [7:0] mem_wdata,
   output reg [7:0] control_reg,
   output reg host_busy
);
`include "cmd_port_defs.vh"
// =========================================
// pin synchronisers and edge detection
reg scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
wire scl_rise = scl_s2 & ~scl_d;
wire scl_fall = ~scl_s2 & scl_d;
wire start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
wire stop_cond = scl_s2 & scl_d & ~sda_d & sda_s2;
always @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
   end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
   end
end
// =========================================
// command helpers
function [3:0] check_range;
   input [15:0] addr;
   input [7:0] len;
   input [7:0] len_max;
   begin
      if (len == 8'h00 || len > len_max || ({8'h00, addr} + {16'h0000, len}) > MEM_SIZE)
         check_range = `RES_PARAM;
      else
         check_range = `RES_NORMAL;
   end
endfunction
// a command is complete once its header and any write data have arrived, or a write length above 251 is seen
function cmd_complete;
   input [7:0] opcode;
   input [7:0] count;
   input [7:0] len;
   begin
      case (opcode)
         `OP_MEM_READ: cmd_complete = (count >= `HDR_LEN_MEM);
         `OP_MEM_WRITE: cmd_complete = (count >= `HDR_LEN_MEM) &&
            (({1'b0, count} >= {1'b0, len} + {1'b0, `HDR_LEN_MEM}) || len > `WRITE_LEN_MAX);
         `OP_REG_WRITE: cmd_complete = (count >= `HDR_LEN_REG_WRITE);
         default: cmd_complete = (count != 8'h00);
      endcase
   end
endfunction
// =========================================
// link state machine
localparam L_IDLE = 3'd0;
localparam L_ADDR = 3'd1;
localparam L_RX = 3'd2;
localparam L_ACK = 3'd3;
localparam L_TX = 3'd4;
localparam L_TXACK = 3'd5;
localparam L_IGNORE = 3'd6;
reg [2:0] lstate;
reg [3:0] bitcnt;
reg [7:0] shreg;
reg reading;
reg ack_ok;
// =========================================
// command assembly and response state
reg [7:0] cmd [0:3]; // opcode, address high, low, length
reg [7:0] rx_count;
reg cmd_pending; // command written, not yet executed
reg [3:0] result;
reg [3:0] flags; // write, read, transmit, detect
reg [7:0] tx_idx;
reg [7:0] resp_data_n;
reg [7:0] reg_rd_byte;
reg wr_active;
reg exec_go;
reg [7:0] tx_byte;
wire [7:0] status_byte = {flags, result};
wire [7:0] op = cmd[0];
wire [15:0] op_addr = {cmd[1], cmd[2]};
wire [15:0] wr_end = op_addr + {8'h00, cmd[3]} - 16'h0001; // last byte of a write
wire in_ro = (op_addr[15:8] <= read_only_area_setting[7:0]) &&
             (wr_end[15:8] >= read_only_area_setting[15:8]);
// response byte selection: status first, then data
always @* begin
   if (tx_idx == 8'h00)
      tx_byte = status_byte; // R10
   else if (op == `OP_REG_READ)
      tx_byte = reg_rd_byte;
   else
      tx_byte = mem_rdata;
end
// byte level receive and transmit on the synchronised pins
always @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      lstate <= L_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      reading <= 1'b0;
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
      ack_ok <= 1'b0;
      rx_count <= 8'h00;
      cmd_pending <= 1'b0;
      tx_idx <= 8'h00;
      exec_go <= 1'b0;
      wr_active <= 1'b0;
      mem_wdata <= 8'h00;
      cmd[0] <= 8'h00;
      cmd[1] <= 8'h00;
      cmd[2] <= 8'h00;
      cmd[3] <= 8'h00;
   end else begin
      exec_go <= 1'b0;
      if (start_cond) begin
         lstate <= L_ADDR;
         bitcnt <= 4'h0;
         sda_oe <= 1'b0; // R01
      end else if (stop_cond) begin
         lstate <= L_IDLE;
         sda_oe <= 1'b0;
         // divided access: execute only once the whole command has arrived
         if (wr_active && cmd_pending && cmd_complete(op, rx_count, cmd[3]))
            exec_go <= 1'b1; // R04 R06
         wr_active <= 1'b0;
      end else begin
         case (lstate)
            L_ADDR, L_RX: begin
               if (scl_rise) begin
                  shreg <= {shreg[6:0], sda_s2};
                  bitcnt <= bitcnt + 4'h1;
               end
               if (scl_fall && bitcnt == 4'h8) begin
                  bitcnt <= 4'h0;
                  if (lstate == L_ADDR) begin
                     if (shreg[7:1] == target_address_setting) begin // R08
                        reading <= shreg[0];
                        sda_oe <= 1'b1;
                        sda_out <= 1'b0;
                        lstate <= L_ACK;
                        if (!shreg[0] && !wr_active) begin // R02
                           wr_active <= 1'b1;
                           if (!cmd_pending) begin
                              rx_count <= 8'h00;
                              cmd_pending <= 1'b1;
                           end
                        end
                        if (shreg[0]) tx_idx <= 8'h00; // R03
                     end else
                        lstate <= L_IGNORE; // R24
                  end else begin
                     if (rx_count < 8'h04) cmd[rx_count[1:0]] <= shreg; // R07
                     if (rx_count != 8'hFF) rx_count <= rx_count + 8'h01;
                     if (rx_count > 8'h03) begin
                        mem_wdata <= shreg;
                     end
                     sda_oe <= 1'b1;
                     sda_out <= 1'b0;
                     lstate <= L_ACK;
                  end
               end
            end
            L_ACK: if (scl_fall) begin
               if (reading) begin
                  sda_oe <= ~tx_byte[7]; sda_out <= 1'b0;
                  shreg <= {tx_byte[6:0], 1'b0};
                  bitcnt <= 4'h1; lstate <= L_TX;
               end else begin
                  sda_oe <= 1'b0; lstate <= L_RX;
               end
            end
            L_TX: if (scl_fall) begin
               if (bitcnt == 4'h8) begin
                  sda_oe <= 1'b0; bitcnt <= 4'h0; lstate <= L_TXACK;
               end else begin
                  sda_oe <= ~shreg[7]; shreg <= {shreg[6:0], 1'b0};
                  bitcnt <= bitcnt + 4'h1;
               end
            end
            L_TXACK: begin
               if (scl_rise) begin
                  ack_ok <= ~sda_s2;
                  if (tx_idx < resp_data_n) tx_idx <= tx_idx + 8'h01; // R22
               end
               if (scl_fall) begin
                  if (ack_ok) begin
                     sda_oe <= ~tx_byte[7]; shreg <= {tx_byte[6:0], 1'b0};
                     bitcnt <= 4'h1; lstate <= L_TX;
                  end else
                     lstate <= L_IGNORE;
               end
            end
            default: lstate <= lstate; // idle, foreign transfer or read ended by a host nack: hands off
         endcase
      end
      if (exec_go) cmd_pending <= 1'b0;
   end
end
// =========================================
// command execution and status
localparam X_IDLE = 2'd0;
localparam X_MEM = 2'd1;
localparam X_WAIT = 2'd2;
reg [1:0] xstate;
reg [7:0] mem_left;
wire [3:0] rd_check = check_range(op_addr, cmd[3], `READ_LEN_MAX);
wire [3:0] wr_check = check_range(op_addr, cmd[3], `WRITE_LEN_MAX);
always @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      xstate <= X_IDLE;
      result <= `RES_NONE;
      flags <= 4'h0;
      host_busy <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_left <= 8'h00;
      control_reg <= 8'h00;
      resp_data_n <= 8'h00;
      reg_rd_byte <= 8'h00;
   end else begin
      // event flags are sticky; a new event wins over the clear on read
      flags <= flags | {rf_mem_write_event, rf_mem_read_event, rf_transmit_done_event, field_detect_event}; // R09
      if (tunnel_read_req) result <= `RES_TUN_READ; // R12
      else if (tunnel_write_req) result <= `RES_TUN_WRITE; // R12
      mem_req <= 1'b0;
      case (xstate)
         X_IDLE: if (exec_go) begin
            resp_data_n <= 8'h00;
            host_busy <= 1'b1; result <= `RES_HOST_BUSY; // R18
            case (op) // R20
               `OP_MEM_READ: begin
                  if (rf_busy) begin result <= `RES_BUSY; host_busy <= 1'b0; end // R17
                  else if (rd_check != `RES_NORMAL) begin result <= `RES_PARAM; host_busy <= 1'b0; end // R14
                  else begin
                     result <= `RES_NORMAL; resp_data_n <= cmd[3]; host_busy <= 1'b0; // R22
                     mem_addr <= op_addr; mem_req <= 1'b1; mem_we <= 1'b0;
                  end
               end
               `OP_MEM_WRITE: begin
                  if (rf_busy) begin result <= `RES_BUSY; host_busy <= 1'b0; end // R17
                  else if (wr_check != `RES_NORMAL) begin result <= `RES_PARAM; host_busy <= 1'b0; end // R14
                  else if (in_ro) begin result <= `RES_RDONLY; host_busy <= 1'b0; end // R15
                  else begin
                     mem_addr <= op_addr; mem_we <= 1'b1; mem_req <= 1'b1;
                     mem_left <= cmd[3]; xstate <= X_WAIT;
                  end
               end
               `OP_REG_READ: begin
                  reg_rd_byte <= {control_reg[7:3], 1'b0, cfg_check_error, sum_check_error};
                  resp_data_n <= 8'h01; result <= `RES_NORMAL; host_busy <= 1'b0; // R19
               end
               `OP_REG_WRITE: begin
                  if (rf_busy) result <= `RES_PARAM; // R19
                  else begin control_reg <= cmd[1] & `CTRL_RESERVED_MASK; result <= `RES_NORMAL; end // R11
                  host_busy <= 1'b0;
               end
               `OP_TUNNEL_A, `OP_TUNNEL_B: begin
                  result <= (!tunnel_mode || rf_busy) ? `RES_TUN_ERR : `RES_NORMAL; // R16
                  host_busy <= 1'b0;
               end
               default: begin result <= `RES_UNIMPL; host_busy <= 1'b0; end // R13
            endcase
         end
         X_WAIT: if (mem_done) begin
            if (mem_left <= 8'h01) begin
               xstate <= X_IDLE; host_busy <= 1'b0; result <= `RES_NORMAL; // R11
            end else begin
               mem_left <= mem_left - 8'h01; mem_addr <= mem_addr + 16'h0001; mem_req <= 1'b1;
            end
         end
         default: xstate <= X_IDLE;
      endcase
      // status-only read: status byte clocked out, acked or not, with no response data bytes to follow
      if (lstate == L_TXACK && scl_fall && tx_idx == 8'h00 && resp_data_n == 8'h00) begin
         if (rf_busy) result <= `RES_BUSY; // R17
         else if (!host_busy) result <= `RES_NONE; // R05 R21
         flags <= {rf_mem_write_event, rf_mem_read_event, rf_transmit_done_event, field_detect_event};
      end
      if (lstate == L_TX && tx_idx != 8'h00 && tx_idx < resp_data_n && !rf_busy && op == `OP_MEM_READ &&
          scl_fall && bitcnt == 4'h8) begin
         mem_addr <= mem_addr + 16'h0001; mem_req <= 1'b1; // R06
      end
   end
end
endmodule
